/* common/alu_ops_pkg.sv */
// Purpose: Shared types and constants for the rotate, subtract, skip and swap datapath.
// Assumes: One 8-bit data memory byte is presented with each request.
// Notes:   Op codes are the sequencer's decoded view, not instruction word encodings.
`default_nettype none

package alu_ops_pkg;

    localparam logic [7:0] WR_RESET      = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] BYTE_ONE      = 8'h01;
    localparam int         MSB_POS       = 7;
    localparam int         NIB_MSB_POS   = 3;

    typedef enum logic [4:0] {
        OP_NOP                  = 5'b00000,
        OP_LOAD_WR              = 5'b00001,
        OP_ROT_LEFT             = 5'b00010,
        OP_ROT_LEFT_COPY        = 5'b00011,
        OP_ROT_LEFT_THRU_CARRY  = 5'b00100,
        OP_ROT_LEFT_THRU_CARRY_COPY = 5'b00101,
        OP_ROT_RIGHT            = 5'b00110,
        OP_ROT_RIGHT_COPY       = 5'b00111,
        OP_ROT_RIGHT_VIA_CY     = 5'b01000,
        OP_ROT_RIGHT_VIA_CY_COPY = 5'b01001,
        OP_MINUS_IMM            = 5'b01010,
        OP_MINUS_MEM            = 5'b01011,
        OP_MINUS_TO_MEM         = 5'b01100,
        OP_SUB_WITH_BORROW_IMM  = 5'b01101,
        OP_SUB_WITH_BORROW      = 5'b01110,
        OP_SUB_WITH_BORROW_TO_MEM = 5'b01111,
        OP_DEC_SKIP_ZERO        = 5'b10000,
        OP_DEC_SKIP_ZERO_COPY   = 5'b10001,
        OP_INC_SKIP_ZERO        = 5'b10010,
        OP_INC_SKIP_ZERO_COPY   = 5'b10011,
        OP_SET_BYTE             = 5'b10100,
        OP_SET_BIT              = 5'b10101,
        OP_SKIP_NONZERO         = 5'b10110,
        OP_SKIP_NONZERO_BIT     = 5'b10111,
        OP_NIBBLE_SWAP          = 5'b11000,
        OP_NIBBLE_EXCHANGE_COPY = 5'b11001
    } alu_op_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
        logic sc;
        logic cz;
    } status_flags_t;

    localparam status_flags_t FLAGS_RESET = '{default: 1'b0};

    typedef struct packed {
        logic       valid;
        alu_op_t    op;
        logic [7:0] mem_data;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } op_req_t;

    typedef struct packed {
        logic       mem_we;
        logic [7:0] mem_wdata;
        logic       skip;
        logic       dummy;
    } alu_result_t;

endpackage : alu_ops_pkg

`default_nettype wire

/* hw/alu_rotate_subtract_skip_ops.sv */
// Purpose: Execute stage for rotate, subtract, skip, set and swap operations.
// Assumes: The sequencer presents the addressed memory byte with each request.
// Notes:   Working register and status flags live here; results appear one cycle later.
`default_nettype none

module alu_rotate_subtract_skip_ops
    import alu_ops_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire op_req_t       req,
    output logic               ready,
    output alu_result_t        res,
    output logic [7:0]         working_register,
    output status_flags_t      flags
);

    typedef struct packed {
        logic [7:0]    wr;
        status_flags_t fl;
        alu_result_t   res;
    } alu_state_t;

    alu_state_t st;
    alu_state_t next_st;

    logic       taken;
    logic [7:0] d;
    logic [7:0] sub_b;
    logic       sub_cin;
    logic [8:0] sub_sum;
    logic [4:0] sub_lo;
    logic [7:0] adj;
    logic       is_skip;

    // A dummy cycle follows every conditional skip, so no request is taken then.
    assign ready = !st.res.dummy;
    assign taken = req.valid && ready;
    assign res = st.res;
    assign working_register = st.wr;
    assign flags = st.fl;

    always_comb
    begin
        d = req.mem_data;
        is_skip = 1'b0;
        adj = BYTE_ZERO;
        // Subtraction as addition of the complement; carry out means no borrow.
        sub_b = (req.op == OP_MINUS_IMM || req.op == OP_SUB_WITH_BORROW_IMM) ? req.imm : d;
        sub_cin = (req.op == OP_SUB_WITH_BORROW || req.op == OP_SUB_WITH_BORROW_IMM ||
                   req.op == OP_SUB_WITH_BORROW_TO_MEM) ? st.fl.c : 1'b1;
        sub_sum = {1'b0, st.wr} + {1'b0, ~sub_b} + {8'h00, sub_cin};
        sub_lo = {1'b0, st.wr[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
        next_st = st;
        next_st.res.mem_we = 1'b0;
        next_st.res.skip = 1'b0;
        next_st.res.dummy = 1'b0;
        if (taken)
        begin
            case (req.op)
                OP_LOAD_WR:
                    next_st.wr = req.imm;
                OP_ROT_LEFT:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = {d[6:0], d[MSB_POS]};
                end
                OP_ROT_LEFT_COPY:
                    next_st.wr = {d[6:0], d[MSB_POS]};
                OP_ROT_LEFT_THRU_CARRY:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = {d[6:0], st.fl.c};
                    next_st.fl.c = d[MSB_POS];
                end
                OP_ROT_LEFT_THRU_CARRY_COPY:
                begin
                    next_st.wr = {d[6:0], st.fl.c};
                    next_st.fl.c = d[MSB_POS];
                end
                OP_ROT_RIGHT:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = {d[0], d[MSB_POS:1]};
                end
                OP_ROT_RIGHT_COPY:
                    next_st.wr = {d[0], d[MSB_POS:1]};
                OP_ROT_RIGHT_VIA_CY:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = {st.fl.c, d[MSB_POS:1]};
                    next_st.fl.c = d[0];
                end
                OP_ROT_RIGHT_VIA_CY_COPY:
                begin
                    next_st.wr = {st.fl.c, d[MSB_POS:1]};
                    next_st.fl.c = d[0];
                end
                OP_MINUS_IMM, OP_MINUS_MEM, OP_MINUS_TO_MEM,
                OP_SUB_WITH_BORROW_IMM, OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_TO_MEM:
                begin
                    if (req.op == OP_MINUS_TO_MEM || req.op == OP_SUB_WITH_BORROW_TO_MEM)
                    begin
                        next_st.res.mem_we = 1'b1;
                        next_st.res.mem_wdata = sub_sum[7:0];
                    end
                    else
                    begin
                        next_st.wr = sub_sum[7:0];
                    end
                    next_st.fl.c = sub_sum[8];
                    next_st.fl.ac = sub_lo[4];
                    next_st.fl.z = (sub_sum[7:0] == BYTE_ZERO);
                    next_st.fl.ov = (st.wr[MSB_POS] != sub_b[MSB_POS]) &&
                                    (sub_sum[MSB_POS] != st.wr[MSB_POS]);
                    next_st.fl.sc = next_st.fl.ov ^ sub_sum[MSB_POS];
                    // Borrow forms chain the zero test across bytes of a wider value.
                    next_st.fl.cz = (sub_sum[7:0] == BYTE_ZERO) &&
                                    ((req.op != OP_SUB_WITH_BORROW &&
                                      req.op != OP_SUB_WITH_BORROW_IMM &&
                                      req.op != OP_SUB_WITH_BORROW_TO_MEM) || st.fl.cz);
                end
                OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_COPY,
                OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_COPY:
                begin
                    is_skip = 1'b1;
                    adj = (req.op == OP_DEC_SKIP_ZERO || req.op == OP_DEC_SKIP_ZERO_COPY)
                        ? d - BYTE_ONE : d + BYTE_ONE;
                    if (req.op == OP_DEC_SKIP_ZERO || req.op == OP_INC_SKIP_ZERO)
                    begin
                        next_st.res.mem_we = 1'b1;
                        next_st.res.mem_wdata = adj;
                    end
                    else
                    begin
                        next_st.wr = adj;
                    end
                    next_st.res.skip = (adj == BYTE_ZERO);
                end
                OP_SET_BYTE:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = BYTE_ALL_ONES;
                end
                OP_SET_BIT:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = d | (BYTE_ONE << req.bit_sel);
                end
                OP_SKIP_NONZERO:
                begin
                    is_skip = 1'b1;
                    next_st.res.skip = (d != BYTE_ZERO);
                end
                OP_SKIP_NONZERO_BIT:
                begin
                    is_skip = 1'b1;
                    next_st.res.skip = d[req.bit_sel];
                end
                OP_NIBBLE_SWAP:
                begin
                    next_st.res.mem_we = 1'b1;
                    next_st.res.mem_wdata = {d[NIB_MSB_POS:0], d[MSB_POS:4]};
                end
                OP_NIBBLE_EXCHANGE_COPY:
                    next_st.wr = {d[NIB_MSB_POS:0], d[MSB_POS:4]};
                default:
                    next_st.wr = st.wr;
            endcase
            next_st.res.dummy = is_skip;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.wr <= WR_RESET;
            st.fl <= FLAGS_RESET;
            st.res <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_rot_left_copy: assert property (taken && req.op == OP_ROT_LEFT_COPY |=>
        st.wr == {$past(req.mem_data[6:0]), $past(req.mem_data[7])} && !st.res.mem_we &&
        st.fl == $past(st.fl)) else $error("rot_left_copy result wrong");
    a_rlc_in_place: assert property (taken && req.op == OP_ROT_LEFT_THRU_CARRY |=>
        st.res.mem_we && st.res.mem_wdata == {$past(req.mem_data[6:0]), $past(st.fl.c)} &&
        st.fl.c == $past(req.mem_data[7]) && st.fl.z == $past(st.fl.z))
        else $error("left rotate through carry wrong");
    a_rlc_copy: assert property (taken && req.op == OP_ROT_LEFT_THRU_CARRY_COPY |=>
        !st.res.mem_we && st.wr == {$past(req.mem_data[6:0]), $past(st.fl.c)} &&
        st.fl.c == $past(req.mem_data[7])) else $error("left rotate copy wrong");
    a_rot_right: assert property (taken && req.op == OP_ROT_RIGHT |=>
        st.res.mem_we && st.res.mem_wdata == {$past(req.mem_data[0]), $past(req.mem_data[7:1])}
        && st.fl == $past(st.fl)) else $error("right rotate wrong");
    a_rot_right_copy: assert property (taken && req.op == OP_ROT_RIGHT_COPY |=>
        !st.res.mem_we && st.wr == {$past(req.mem_data[0]), $past(req.mem_data[7:1])})
        else $error("right rotate copy wrong");
    a_rrc_in_place: assert property (taken && req.op == OP_ROT_RIGHT_VIA_CY |=>
        st.res.mem_wdata == {$past(st.fl.c), $past(req.mem_data[7:1])} &&
        st.fl.c == $past(req.mem_data[0])) else $error("right rotate through carry wrong");
    a_rrc_copy: assert property (taken && req.op == OP_ROT_RIGHT_VIA_CY_COPY |=>
        st.wr == {$past(st.fl.c), $past(req.mem_data[7:1])} &&
        st.fl.c == $past(req.mem_data[0])) else $error("right rotate copy through carry wrong");
    a_borrow_result: assert property (taken && req.op == OP_SUB_WITH_BORROW |=>
        st.wr == 8'($past(st.wr) - $past(req.mem_data) - {7'h00, !$past(st.fl.c)}))
        else $error("subtract with borrow result wrong");
    a_sub_carry: assert property (taken && req.op == OP_MINUS_MEM |=>
        st.fl.c == ($past(st.wr) >= $past(req.mem_data))) else $error("subtract carry wrong");
    a_sub_zero_flag: assert property (taken && req.op == OP_MINUS_MEM |=>
        st.fl.z == (st.wr == BYTE_ZERO) && st.fl.sc == (st.fl.ov ^ st.wr[7]))
        else $error("subtract zero or signed flag wrong");
    a_sub_imm: assert property (taken && req.op == OP_MINUS_IMM |=>
        st.wr == 8'($past(st.wr) - $past(req.imm))) else $error("immediate subtract wrong");
    a_minus_mem: assert property (taken && req.op == OP_MINUS_TO_MEM |=>
        st.res.mem_we && st.res.mem_wdata == 8'($past(st.wr) - $past(req.mem_data)) &&
        st.wr == $past(st.wr)) else $error("subtract to memory wrong");
    a_dec_skip: assert property (taken && req.op == OP_DEC_SKIP_ZERO |=>
        st.res.mem_we && st.res.mem_wdata == 8'($past(req.mem_data) - 8'h01) &&
        st.res.skip == ($past(req.mem_data) == 8'h01) && st.fl == $past(st.fl))
        else $error("decrement skip wrong");
    a_inc_skip: assert property (taken && req.op == OP_INC_SKIP_ZERO |=>
        st.res.mem_wdata == 8'($past(req.mem_data) + 8'h01) &&
        st.res.skip == ($past(req.mem_data) == 8'hFF)) else $error("increment skip wrong");
    a_skip_copy: assert property (taken && req.op == OP_INC_SKIP_ZERO_COPY |=>
        !st.res.mem_we && st.res.skip == (st.wr == BYTE_ZERO)) else $error("copy skip wrong");
    a_skip_dummy: assert property (taken && (req.op == OP_SKIP_NONZERO ||
        req.op == OP_DEC_SKIP_ZERO) |=> !ready ##1 ready) else $error("dummy cycle missing");
    a_set_bit: assert property (taken && req.op == OP_SET_BIT |=>
        st.res.mem_wdata[$past(req.bit_sel)] && st.fl == $past(st.fl))
        else $error("bit set wrong");
    a_skip_nz: assert property (taken && req.op == OP_SKIP_NONZERO |=>
        st.res.skip == ($past(req.mem_data) != 8'h00) && !st.res.mem_we)
        else $error("skip nonzero wrong");
    a_swap_mem: assert property (taken && req.op == OP_NIBBLE_SWAP |=>
        st.res.mem_wdata == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])})
        else $error("nibble swap wrong");
    a_swap_copy: assert property (taken && req.op == OP_NIBBLE_EXCHANGE_COPY |=>
        !st.res.mem_we && st.wr == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])})
        else $error("nibble exchange copy wrong");
    a_one_cycle_we: assert property (taken && req.op == OP_SET_BYTE |=>
        st.res.mem_we && st.res.mem_wdata == 8'hFF ##1 (!st.res.mem_we || $past(taken)))
        else $error("memory write not single cycle");
    a_rot_left_mem: assert property (taken && req.op == OP_ROT_LEFT |=>
        st.res.mem_we && st.res.mem_wdata == {$past(req.mem_data[6:0]), $past(req.mem_data[7])}
        && st.fl == $past(st.fl)) else $error("left rotate in place wrong");
    a_borrow_to_mem: assert property (taken &&
        req.op == OP_SUB_WITH_BORROW_TO_MEM |=> st.res.mem_we && st.wr == $past(st.wr) &&
        st.res.mem_wdata == 8'($past(st.wr) - $past(req.mem_data) - {7'h00, !$past(st.fl.c)}))
        else $error("subtract with borrow to memory wrong");
    a_sub_overflow: assert property (taken && req.op == OP_MINUS_MEM |=>
        st.fl.ov == (($past(st.wr[7]) != $past(req.mem_data[7])) &&
                     (st.wr[7] != $past(st.wr[7]))))
        else $error("subtract overflow flag wrong");
    a_sub_half_carry: assert property (taken && req.op == OP_MINUS_MEM |=>
        st.fl.ac == ($past(st.wr[3:0]) >= $past(req.mem_data[3:0])) && st.fl.cz == st.fl.z)
        else $error("subtract half carry or chained zero wrong");
    a_dec_copy: assert property (taken && req.op == OP_DEC_SKIP_ZERO_COPY |=>
        !st.res.mem_we && st.wr == 8'($past(req.mem_data) - 8'h01) &&
        st.res.skip == ($past(req.mem_data) == 8'h01)) else $error("decrement copy skip wrong");
    a_skip_nz_bit: assert property (taken && req.op == OP_SKIP_NONZERO_BIT |=>
        st.res.skip == $past(req.mem_data[req.bit_sel]) && !st.res.mem_we && st.res.dummy)
        else $error("skip on bit wrong");
    a_dummy_refuse: assert property (!ready |=> !st.res.mem_we && !st.res.skip &&
        st.wr == $past(st.wr) && st.fl == $past(st.fl))
        else $error("request taken in dummy cycle");
    a_swap_flags: assert property (taken && req.op == OP_NIBBLE_SWAP |=>
        st.res.mem_we && st.fl == $past(st.fl) && st.wr == $past(st.wr))
        else $error("nibble swap touched flags or register");

    c_skip_taken: cover property (taken && req.op == OP_DEC_SKIP_ZERO ##1 st.res.skip);
    c_borrow_negative: cover property (taken && req.op == OP_SUB_WITH_BORROW ##1 !st.fl.c);
    c_rlc_carry_out: cover property (taken && req.op == OP_ROT_LEFT_THRU_CARRY ##1 st.fl.c);
    c_back_to_back: cover property (taken ##1 taken ##1 taken);
    c_bit_skip: cover property (taken && req.op == OP_SKIP_NONZERO_BIT ##1 st.res.skip);

endmodule : alu_rotate_subtract_skip_ops

`default_nettype wire

/* verif/mem_partner.sv */
// Purpose: Data memory and sequencer write path that sit beside the execute stage.
// Assumes: Each mem_we pulse writes the address of the request taken one edge before.
// Notes:   Read data forwards a pending write, so back-to-back ops see the fresh byte.
`default_nettype none

module mem_partner
    import alu_ops_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        take,
    input  wire logic [3:0]  addr,
    input  wire alu_result_t res,
    output logic [7:0]       rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [16];
    logic [3:0] waddr;

    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 8'(i * 37);
        end
    end

    assign rdata = (res.mem_we && waddr == addr) ? res.mem_wdata : mem[addr];

    always @(posedge clk)
    begin
        if (take)
        begin
            waddr <= addr;
        end
        if (res.mem_we)
        begin
            mem[waddr] <= res.mem_wdata;
        end
    end
endmodule // mem_partner

`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the rotate, subtract, skip, set and swap stage.
// Assumes: Inputs change 1 ns after the rising edge; results are read 1 ns after the next.
// Notes:   A request is held through each dummy cycle to show that it is refused.
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("unexpected %s exp %0h got %0h", nm, e, g); \
        end \
    end

module tb_top
    import alu_ops_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk;
    logic          rst;
    logic          vld;
    alu_op_t       op;
    logic [7:0]    imm;
    logic [2:0]    bsel;
    logic [3:0]    addr;
    logic [7:0]    rdata;
    op_req_t       req;
    logic          ready;
    alu_result_t   res;
    logic [7:0]    wr;
    status_flags_t fl;
    logic [7:0]    exp_mem [16];
    logic [7:0]    exp_wr;
    status_flags_t exp_fl;
    logic [31:0]   rv;
    int            miscompares;
    int            n_tests;
    int            seed;

    assign req = '{valid: vld, op: op, mem_data: rdata, imm: imm, bit_sel: bsel};

    alu_rotate_subtract_skip_ops DUT (
        .clk              (clk),
        .rst              (rst),
        .req              (req),
        .ready            (ready),
        .res              (res),
        .working_register (wr),
        .flags            (fl)
    );

    mem_partner u_mem (
        .clk   (clk),
        .take  (vld && ready),
        .addr  (addr),
        .res   (res),
        .rdata (rdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Borrow forms pass the old carry as cin; plain forms pass 1.
    function automatic logic [7:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic brw);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + 9'(cin);
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
        exp_fl.c  = s[8];
        exp_fl.ac = h[4];
        exp_fl.ov = (a[7] != b[7]) && (s[7] != a[7]);
        exp_fl.sc = exp_fl.ov ^ s[7];
        exp_fl.cz = (s[7:0] == 8'h00) && (!brw || exp_fl.cz);
        exp_fl.z  = s[7:0] == 8'h00;
        return s[7:0];
    endfunction

    task automatic idle();
        vld = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input int n);
        rst = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        rst = 1'b0;
        exp_wr = WR_RESET;
        exp_fl = FLAGS_RESET;
        `CHK("reset state", {WR_RESET, FLAGS_RESET, 4'h1},
             {wr, fl, res.mem_we, res.skip, res.dummy, ready})
    endtask

    task automatic run_op(input alu_op_t o, input logic [3:0] a, input logic [7:0] i,
                          input logic [2:0] bs);
        logic [7:0] m;
        logic [7:0] r;
        logic       we;
        logic       towr;
        logic       dm;
        logic       sk;
        m = exp_mem[a];
        case (o)
            OP_LOAD_WR: r = i;
            OP_ROT_LEFT, OP_ROT_LEFT_COPY: r = {m[6:0], m[7]};
            OP_ROT_LEFT_THRU_CARRY, OP_ROT_LEFT_THRU_CARRY_COPY: r = {m[6:0], exp_fl.c};
            OP_ROT_RIGHT, OP_ROT_RIGHT_COPY: r = {m[0], m[7:1]};
            OP_ROT_RIGHT_VIA_CY, OP_ROT_RIGHT_VIA_CY_COPY: r = {exp_fl.c, m[7:1]};
            OP_MINUS_IMM: r = sub8(exp_wr, i, 1'b1, 1'b0);
            OP_MINUS_MEM, OP_MINUS_TO_MEM: r = sub8(exp_wr, m, 1'b1, 1'b0);
            OP_SUB_WITH_BORROW_IMM: r = sub8(exp_wr, i, exp_fl.c, 1'b1);
            OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_TO_MEM: r = sub8(exp_wr, m, exp_fl.c, 1'b1);
            OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_COPY: r = m - BYTE_ONE;
            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_COPY: r = m + BYTE_ONE;
            OP_SET_BYTE: r = BYTE_ALL_ONES;
            OP_SET_BIT: r = m | (BYTE_ONE << bs);
            OP_NIBBLE_SWAP, OP_NIBBLE_EXCHANGE_COPY: r = {m[3:0], m[7:4]};
            default: r = m;
        endcase
        if (o inside {OP_ROT_LEFT_THRU_CARRY, OP_ROT_LEFT_THRU_CARRY_COPY})
            exp_fl.c = m[7];
        if (o inside {OP_ROT_RIGHT_VIA_CY, OP_ROT_RIGHT_VIA_CY_COPY})
            exp_fl.c = m[0];
        we = o inside {OP_ROT_LEFT, OP_ROT_LEFT_THRU_CARRY, OP_ROT_RIGHT, OP_ROT_RIGHT_VIA_CY,
                       OP_MINUS_TO_MEM, OP_SUB_WITH_BORROW_TO_MEM, OP_DEC_SKIP_ZERO,
                       OP_INC_SKIP_ZERO, OP_SET_BYTE, OP_SET_BIT, OP_NIBBLE_SWAP};
        towr = o inside {OP_LOAD_WR, OP_ROT_LEFT_COPY, OP_ROT_LEFT_THRU_CARRY_COPY,
                         OP_ROT_RIGHT_COPY, OP_ROT_RIGHT_VIA_CY_COPY, OP_MINUS_IMM, OP_MINUS_MEM,
                         OP_SUB_WITH_BORROW_IMM, OP_SUB_WITH_BORROW, OP_DEC_SKIP_ZERO_COPY,
                         OP_INC_SKIP_ZERO_COPY, OP_NIBBLE_EXCHANGE_COPY};
        dm = o inside {OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_COPY, OP_INC_SKIP_ZERO,
                       OP_INC_SKIP_ZERO_COPY, OP_SKIP_NONZERO, OP_SKIP_NONZERO_BIT};
        sk = (dm && o < OP_SKIP_NONZERO && r == BYTE_ZERO) || (o == OP_SKIP_NONZERO && m != 0)
             || (o == OP_SKIP_NONZERO_BIT && m[bs]);
        if (we)
            exp_mem[a] = r;
        if (towr)
            exp_wr = r;
        vld = 1'b1;
        op = o;
        addr = a;
        imm = i;
        bsel = bs;
        @(posedge clk);
        #1;
        `CHK("skip", sk, res.skip)
        `CHK("dummy and ready", {dm, !dm}, {res.dummy, ready})
        if (we) `CHK("mem write", {1'b1, r}, {res.mem_we, res.mem_wdata})
        else `CHK("no mem write", 1'b0, res.mem_we)
        `CHK("working_register", exp_wr, wr)
        `CHK("flags", exp_fl, fl)
        if (dm)
        begin
            // A write request during the dummy cycle must be ignored.
            op = OP_SET_BYTE;
            @(posedge clk);
            #1;
            `CHK("dummy end", 4'h1, {res.dummy, res.skip, res.mem_we, ready})
        end
    endtask

    task automatic sweep(input string nm);
        idle();
        idle();
        for (int i = 0; i < 16; i++)
            `CHK("memory byte", exp_mem[i], u_mem.mem[i])
        $display("test %s done", nm);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        seed = 32'h1c35311e;
        miscompares = 0;
        n_tests = 0;
        rst = 1'b1;
        vld = 1'b0;
        op = OP_NOP;
        imm = 8'h00;
        bsel = 3'h0;
        addr = 4'h0;
        @(posedge clk);
        #1;
        do_reset(20);
        for (int i = 0; i < 16; i++)
            exp_mem[i] = u_mem.mem[i];
        run_op(OP_SET_BYTE, 4'h1, 8'h00, 3'h0);
        run_op(OP_INC_SKIP_ZERO_COPY, 4'h1, 8'h00, 3'h0);
        run_op(OP_INC_SKIP_ZERO, 4'h1, 8'h00, 3'h0);
        run_op(OP_DEC_SKIP_ZERO, 4'h1, 8'h00, 3'h0);
        run_op(OP_SKIP_NONZERO, 4'h0, 8'h00, 3'h0);
        run_op(OP_SET_BIT, 4'h2, 8'h00, 3'h7);
        run_op(OP_SKIP_NONZERO_BIT, 4'h2, 8'h00, 3'h7);
        run_op(OP_LOAD_WR, 4'h0, 8'h80, 3'h0);
        run_op(OP_MINUS_IMM, 4'h0, 8'h01, 3'h0);
        run_op(OP_SUB_WITH_BORROW_IMM, 4'h0, 8'h80, 3'h0);
        run_op(OP_ROT_LEFT_THRU_CARRY, 4'h1, 8'h00, 3'h0);
        run_op(OP_ROT_RIGHT_VIA_CY_COPY, 4'h2, 8'h00, 3'h0);
        sweep("corners");
        for (int k = 0; k < 26; k++)
            run_op(alu_op_t'(k), 4'(k), 8'(k * 11), 3'(k));
        sweep("every code");
        for (int k = 0; k < 400; k++)
        begin
            rv = $random(seed);
            if (k == 200)
                do_reset(3);
            if (rv[1:0] == 2'h0)
                idle();
            run_op(alu_op_t'(rv[12:8] % 5'd26), rv[19:16], rv[31:24], rv[22:20]);
        end
        sweep("random");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
